// file: logic/sxr_redirect.v
/*
 security exception init redirect: diverts an external reinitialisation
 request into a security exception while redirect is enabled, and sets up
 the control flags when a startup interprocessor interrupt arrives after
 the bootstrap processor has performed the secure launch.
 assumes the init pin and startup pulse come from outside the clock domain,
 flag writes and dispatch acknowledge come from core logic on ref_clk.
*/
// Function
// - redirect enabled: an external init becomes a security exception, no reinit
// - security exception dispatches on vector 30 as a fault, like protection fault
// - security exception pushes error code 1, meaning init was redirected
// - security exception is contributory for double-fault escalation
// - startup ipi after secure launch sets redirect, debug, wrap flags, clears interrupt flag
`timescale 1ns/1ps
`include "sxr_defines.vh"
module sxr_redirect (
	input wire ref_clk,
	input wire rst_b,
	input wire init_pin,
	input wire startup_ipi_pin,
	input wire secure_launch_done,
	input wire flag_wr,
	input wire redirect_wr_val,
	input wire debug_disable_flag_wr_val,
	input wire address_wrap_disable_flag_wr_val,
	input wire global_interrupt_flag_wr,
	input wire global_interrupt_flag_wr_val,
	input wire dispatch_ack,
	output reg init_do_q,
	output reg exc_valid_q,
	output reg [`SXR_VEC_W-1:0] exc_vector_q,
	output reg exc_is_fault_q,
	output reg exc_has_err_q,
	output reg [`SXR_ERR_W-1:0] exc_err_code_q,
	output reg [`SXR_CLASS_W-1:0] exc_class_q,
	output reg redirect_en_q,
	output reg debug_disable_flag_q,
	output reg address_wrap_disable_flag_q,
	output reg global_interrupt_flag_q
);
	localparam ST_IDLE = 2'b01;
	localparam ST_PEND = 2'b10;

	wire init_s;
	wire sipi_s;
	wire init_rise;
	wire sipi_rise;
	wire init_seen;
	wire launch_sipi;
	wire raise_exc;
	wire take_exc;
	reg init_prev_q;
	reg sipi_prev_q;
	reg init_held_q;
	reg init_held_d;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg init_do_d;
	reg exc_valid_d;
	reg redirect_en_d;
	reg debug_disable_flag_d;
	reg address_wrap_disable_flag_d;
	reg global_interrupt_flag_d;

	sxr_sync u_sync_init (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.async_in(init_pin),
		.sync_q(init_s)
	);

	sxr_sync u_sync_sipi (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.async_in(startup_ipi_pin),
		.sync_q(sipi_s)
	);

	assign init_rise = init_s & ~init_prev_q;
	assign sipi_rise = sipi_s & ~sipi_prev_q;
	// init waits while the global interrupt flag is clear
	assign init_seen = (init_rise | init_held_q) & global_interrupt_flag_q;
	// startup event only counts after the secure launch
	assign launch_sipi = sipi_rise & secure_launch_done;
	assign raise_exc = (state_q == ST_IDLE) & (state_d == ST_PEND);
	assign take_exc = (state_q == ST_PEND) & dispatch_ack;

	// previous synchronised levels for edge detection
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			init_prev_q <= 1'b0;
			sipi_prev_q <= 1'b0;
		end else begin
			init_prev_q <= init_s;
			sipi_prev_q <= sipi_s;
		end
	end

	// one held request at most; later ones merge into it
	always @* begin
		init_held_d = init_held_q;
		if (init_rise & ~global_interrupt_flag_q)
			init_held_d = 1'b1;
		else if (init_seen)
			init_held_d = 1'b0;
	end

	always @(posedge ref_clk) begin
		if (!rst_b)
			init_held_q <= 1'b0;
		else
			init_held_q <= init_held_d;
	end

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (init_seen & redirect_en_q)
					state_d = ST_PEND;
			end
			ST_PEND: begin
				if (dispatch_ack)
					state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge ref_clk) begin
		if (!rst_b)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// plain init when redirect is off
	always @* begin
		init_do_d = 1'b0;
		if (init_seen & ~redirect_en_q & (state_q == ST_IDLE))
			init_do_d = 1'b1;
	end

	// exception stays raised until dispatch takes it
	always @* begin
		exc_valid_d = exc_valid_q;
		if (raise_exc)
			exc_valid_d = 1'b1;
		else if (take_exc)
			exc_valid_d = 1'b0;
	end

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			init_do_q <= 1'b0;
			exc_valid_q <= 1'b0;
		end else begin
			init_do_q <= init_do_d;
			exc_valid_q <= exc_valid_d;
		end
	end

	// fields keep the last exception after dispatch
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			exc_vector_q <= {`SXR_VEC_W{1'b0}};
			exc_is_fault_q <= 1'b0;
			exc_has_err_q <= 1'b0;
			exc_err_code_q <= {`SXR_ERR_W{1'b0}};
			exc_class_q <= `SXR_CLASS_BENIGN;
		end else if (raise_exc) begin
			exc_vector_q <= `SXR_VEC_SECURITY;
			exc_is_fault_q <= 1'b1;
			exc_has_err_q <= 1'b1;
			exc_err_code_q <= `SXR_ERR_INIT_REDIRECT;
			exc_class_q <= `SXR_CLASS_CONTRIB;
		end
	end

	// startup ipi wins over a same-cycle software write
	always @* begin
		redirect_en_d = redirect_en_q;
		debug_disable_flag_d = debug_disable_flag_q;
		address_wrap_disable_flag_d = address_wrap_disable_flag_q;
		if (launch_sipi) begin
			redirect_en_d = 1'b1;
			debug_disable_flag_d = 1'b1;
			address_wrap_disable_flag_d = 1'b1;
		end else if (flag_wr) begin
			redirect_en_d = redirect_wr_val;
			debug_disable_flag_d = debug_disable_flag_wr_val;
			address_wrap_disable_flag_d = address_wrap_disable_flag_wr_val;
		end
	end

	always @* begin
		global_interrupt_flag_d = global_interrupt_flag_q;
		if (launch_sipi)
			global_interrupt_flag_d = 1'b0;
		else if (global_interrupt_flag_wr)
			global_interrupt_flag_d = global_interrupt_flag_wr_val;
	end

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			redirect_en_q <= `SXR_RST_REDIRECT;
			debug_disable_flag_q <= `SXR_RST_DEBUG_DIS;
			address_wrap_disable_flag_q <= `SXR_RST_WRAP_DIS;
			global_interrupt_flag_q <= `SXR_RST_GLOBAL_INT_FLAG;
		end else begin
			redirect_en_q <= redirect_en_d;
			debug_disable_flag_q <= debug_disable_flag_d;
			address_wrap_disable_flag_q <= address_wrap_disable_flag_d;
			global_interrupt_flag_q <= global_interrupt_flag_d;
		end
	end
endmodule // sxr_redirect

// file: logic/sxr_defines.vh
/*
 holds constants of the security exception redirect block: vector, error
 code, exception class codes and reset values of the control flags.
 assumes inclusion by bare name from the block's design files.
*/
`ifndef SXR_DEFINES_VH
`define SXR_DEFINES_VH

`define SXR_VEC_W 8
`define SXR_VEC_SECURITY 8'h1e
`define SXR_ERR_W 32
`define SXR_ERR_INIT_REDIRECT 32'h00000001
`define SXR_CLASS_W 2
`define SXR_CLASS_BENIGN 2'h0
`define SXR_CLASS_CONTRIB 2'h1
`define SXR_CLASS_PAGEFAULT 2'h2
`define SXR_RST_REDIRECT 1'b0
`define SXR_RST_DEBUG_DIS 1'b0
`define SXR_RST_WRAP_DIS 1'b0
`define SXR_RST_GLOBAL_INT_FLAG 1'b1

`endif

// file: logic/sxr_sync.v
/*
 two-flop synchroniser for one level from outside the clock domain.
 assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module sxr_sync (
	input wire ref_clk,
	input wire rst_b,
	input wire async_in,
	output reg sync_q
);
	reg meta_q;

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
endmodule // sxr_sync

// file: verification/sxr_props.sv
/* checker of the redirect block; sees its ports only */
`timescale 1ns/1ps
module sxr_props (input wire ref_clk, input wire rst_b, input wire init_pin,
	input wire startup_ipi_pin, input wire secure_launch_done, input wire dispatch_ack,
	input wire init_do_q, input wire exc_valid_q, input wire [7:0] exc_vector_q,
	input wire exc_is_fault_q, input wire exc_has_err_q, input wire [31:0] exc_err_code_q,
	input wire [1:0] exc_class_q, input wire redirect_en_q,
	input wire global_interrupt_flag_q);
default clocking @(posedge ref_clk); endclocking
default disable iff (!rst_b);
a_exc_needs_redir: assert property ($rose(exc_valid_q) |-> redirect_en_q)
	else $error("exc raised without redirect");
a_init_redirected: assert property ($rose(init_pin) && redirect_en_q
	&& global_interrupt_flag_q && !exc_valid_q |-> ##[2:6] exc_valid_q)
	else $error("init not redirected");
a_no_plain_init: assert property (init_do_q |-> !redirect_en_q && !exc_valid_q)
	else $error("init done while redirecting");
a_plain_init: assert property ($rose(init_pin) && !redirect_en_q
	&& global_interrupt_flag_q |-> ##[2:6] init_do_q) else $error("init not done");
a_vector_fault: assert property (exc_valid_q |-> exc_vector_q == 8'h1e && exc_is_fault_q)
	else $error("bad vector");
a_error_code: assert property (exc_valid_q |-> exc_has_err_q && exc_err_code_q == 32'h1)
	else $error("bad error code");
a_contrib_class: assert property (exc_valid_q |-> exc_class_q == 2'h1)
	else $error("bad class");
a_exc_holds: assert property (exc_valid_q && !dispatch_ack |=> exc_valid_q)
	else $error("exc dropped");
a_sipi_flags: assert property ($rose(startup_ipi_pin) && secure_launch_done
	|-> ##[2:5] (redirect_en_q && !global_interrupt_flag_q)) else $error("flags not set");
cover property ($rose(exc_valid_q));
cover property (init_do_q);
cover property ($fell(global_interrupt_flag_q));
endmodule // sxr_props
bind sxr_redirect sxr_props sxr_props_i (
	.ref_clk(ref_clk),
	.rst_b(rst_b),
	.init_pin(init_pin),
	.startup_ipi_pin(startup_ipi_pin),
	.secure_launch_done(secure_launch_done),
	.dispatch_ack(dispatch_ack),
	.init_do_q(init_do_q),
	.exc_valid_q(exc_valid_q),
	.exc_vector_q(exc_vector_q),
	.exc_is_fault_q(exc_is_fault_q),
	.exc_has_err_q(exc_has_err_q),
	.exc_err_code_q(exc_err_code_q),
	.exc_class_q(exc_class_q),
	.redirect_en_q(redirect_en_q),
	.global_interrupt_flag_q(global_interrupt_flag_q)
);

// file: verification/sxr_far.sv
/* init source and dispatch model; driven on falling edges */
`timescale 1ns/1ps
module sxr_far (input wire ref_clk, input wire go, input wire slow, input wire exc_valid_q,
	output reg init_pin, output reg dispatch_ack);
reg [1:0] w_q = 2'h0;
initial init_pin = 1'b0;
initial dispatch_ack = 1'b0;
always @(negedge ref_clk) begin
	init_pin <= go;
	dispatch_ack <= 1'b0;
	if (exc_valid_q && !dispatch_ack) begin
		// slow dispatch waits four cycles
		w_q <= w_q + 2'h1;
		if (!slow || w_q == 2'h3) begin
			dispatch_ack <= 1'b1;
			w_q <= 2'h0;
		end
	end
end
endmodule // sxr_far

// file: verification/security_exception_init_redirect_test.sv
/* bench of the redirect block; uses sxr_far as far side */
`timescale 1ns/1ps
module security_exception_init_redirect_test;
reg ref_clk = 0, rst_b = 0, startup_ipi_pin = 0, secure_launch_done = 0, flag_wr = 0;
reg redirect_wr_val = 0, global_interrupt_flag_wr = 0, global_interrupt_flag_wr_val = 0;
reg go = 0, slow = 0, se, si;
reg [11:0] sf;
reg [31:0] ec;
wire debug_disable_flag_wr_val = redirect_wr_val;
wire address_wrap_disable_flag_wr_val = redirect_wr_val;
wire init_pin, dispatch_ack, init_do_q, exc_valid_q, exc_is_fault_q, exc_has_err_q;
wire redirect_en_q, debug_disable_flag_q, address_wrap_disable_flag_q, global_interrupt_flag_q;
wire [7:0] exc_vector_q;
wire [31:0] exc_err_code_q;
wire [1:0] exc_class_q;
integer err_total = 0, checks = 0, i, t = 0;
reg [3:0] rows [0:3];
sxr_redirect sxr_redirect_i (
	.ref_clk(ref_clk),
	.rst_b(rst_b),
	.init_pin(init_pin),
	.startup_ipi_pin(startup_ipi_pin),
	.secure_launch_done(secure_launch_done),
	.flag_wr(flag_wr),
	.redirect_wr_val(redirect_wr_val),
	.debug_disable_flag_wr_val(debug_disable_flag_wr_val),
	.address_wrap_disable_flag_wr_val(address_wrap_disable_flag_wr_val),
	.global_interrupt_flag_wr(global_interrupt_flag_wr),
	.global_interrupt_flag_wr_val(global_interrupt_flag_wr_val),
	.dispatch_ack(dispatch_ack),
	.init_do_q(init_do_q),
	.exc_valid_q(exc_valid_q),
	.exc_vector_q(exc_vector_q),
	.exc_is_fault_q(exc_is_fault_q),
	.exc_has_err_q(exc_has_err_q),
	.exc_err_code_q(exc_err_code_q),
	.exc_class_q(exc_class_q),
	.redirect_en_q(redirect_en_q),
	.debug_disable_flag_q(debug_disable_flag_q),
	.address_wrap_disable_flag_q(address_wrap_disable_flag_q),
	.global_interrupt_flag_q(global_interrupt_flag_q)
);
sxr_far sxr_far_i (.ref_clk(ref_clk), .go(go), .slow(slow), .exc_valid_q(exc_valid_q),
	.init_pin(init_pin), .dispatch_ack(dispatch_ack));
always #12.5 ref_clk = ~ref_clk;
always @(posedge ref_clk) begin
	t = t + 1;
	if (t == 600) begin
		err_total = err_total + 1;
		complete_run;
	end
end
task complete_run;
	begin
		$display("err_total=%0d checks=%0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
endtask
task cmp(input [31:0] g, input [31:0] e);
	begin
		checks = checks + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	end
endtask
task fire;
	begin
		se = 0;
		si = 0;
		@(negedge ref_clk) go <= 1;
		@(negedge ref_clk) go <= 0;
		repeat (8) @(negedge ref_clk) begin
			se |= exc_valid_q;
			si |= init_do_q;
			if (exc_valid_q) begin
				sf = {exc_is_fault_q, exc_has_err_q, exc_class_q, exc_vector_q};
				ec = exc_err_code_q;
			end
		end
	end
endtask
initial begin
	// rows: slow dispatch, redirect, exc expected, init expected
	rows[0] = 4'h6;
	rows[1] = 4'h1;
	rows[2] = 4'he;
	rows[3] = 4'h9;
	repeat (8) @(negedge ref_clk);
	rst_b = 1;
	@(negedge ref_clk);
	cmp({redirect_en_q, debug_disable_flag_q, address_wrap_disable_flag_q,
		global_interrupt_flag_q, exc_valid_q, init_do_q}, 6'h04);
	$display("reset test done");
	for (i = 0; i < 4; i++) begin
		slow = rows[i][3];
		redirect_wr_val = rows[i][2];
		flag_wr = 1;
		@(negedge ref_clk) flag_wr = 0;
		fire;
		cmp(se, rows[i][1]);
		cmp(si, rows[i][0]);
		$display("row %0d done", i);
	end
	cmp(sf, 12'hd1e);
	cmp(ec, 32'h1);
	secure_launch_done = 1;
	startup_ipi_pin = 1;
	repeat (3) @(negedge ref_clk);
	startup_ipi_pin = 0;
	repeat (4) @(negedge ref_clk);
	cmp({redirect_en_q, debug_disable_flag_q, address_wrap_disable_flag_q,
		global_interrupt_flag_q}, 4'he);
	$display("startup test done");
	fire;
	cmp({se, si}, 2'h0);
	global_interrupt_flag_wr = 1;
	global_interrupt_flag_wr_val = 1;
	@(negedge ref_clk) global_interrupt_flag_wr = 0;
	repeat (8) @(negedge ref_clk) se |= exc_valid_q;
	cmp(se, 1);
	$display("held init test done");
	complete_run;
end
endmodule // security_exception_init_redirect_test
